// >>> rtl/dcbf_pkg.sv
package dcbf_pkg;

  // ----------------------------------------------------------------
  // counts and reset values
  // ----------------------------------------------------------------
  localparam int          BUF_DEPTH_C   = 8;      // words held in the write-side buffer
  localparam int          FALL_TRANS_C  = 3;      // read clock transitions before a word falls through
  localparam int          BYTE_W_C      = 9;      // one narrow word
  localparam int          WORD_W_C      = 18;     // one wide word
  localparam int          OFS_W_C       = 16;     // width of the default offset table entries
  localparam logic        NEAR_E_RST_C  = 1'b0;   // near empty asserted after reset
  localparam logic        NEAR_F_RST_C  = 1'b1;   // near full released after reset
  localparam logic        HALF_RST_C    = 1'b1;   // half level released after reset

  // default offsets, indexed by {default_offset_sel1, default_offset_sel0, offset_load_n}
  localparam logic [OFS_W_C-1:0] DEF_OFS_C [8] = '{
    16'h0007, 16'h000f, 16'h001f, 16'h003f,
    16'h007f, 16'h00ff, 16'h01ff, 16'h03ff
  };

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // every pin that arrives from outside the reference clock domain
  typedef struct packed {
    logic        wclk;
    logic        rclk;
    logic        wen_n;
    logic        ren_n;
    logic        oe_n;
    logic        ld_n;
    logic        sen_n;
    logic        si;        // fall-through select at master reset, serial data after
    logic        rt_n;
    logic        mrs_n;
    logic        prs_n;
    logic        iw;
    logic        ow;
    logic        be;
    logic        flag_sync_select;
    logic        rm;
    logic        default_offset_sel0;
    logic        default_offset_sel1;
    logic        ip;
    logic [17:0] d;
  } dcbf_pins_t;

  // mode selections caught during master reset
  typedef struct packed {
    logic fall_through_mode;
    logic in9;
    logic out9;
    logic little;
    logic sync_flags;
    logic norm_rt;
    logic ip;
  } dcbf_cfg_t;

  // one entry of the write-side buffer
  typedef struct packed {
    logic        wide;
    logic [17:0] data;
  } dcbf_buf_word_t;

endpackage

// >>> rtl/dcbf_fifo.sv
`timescale 1ns/1ps
// Notes on behaviour
// - port widths chosen at master reset
// - write edge with enable stores input word
// - read edge with enable advances next word
// - outputs driven only while output enabled
// - clocks fully independent, any rate up
// - fall-through: first word after three transitions
// - shared pin selects timing, then serial data
// - standard mode: first word needs read
// - fall-through outputs chain into next inputs
// - flag meaning follows timing mode
// - threshold offsets; eight defaults at reset
// - serial offset load one bit per edge
// - parallel offset load from input bus
// - offset readback with read and load
// - asynchronous near-empty: low read, high write
// - synchronous threshold flags per own clock
// - retransmit moves read pointer to start
// - retransmit latency chosen at master reset
// - zero latency: first word same edge
// - master reset latches modes, clears flags
// - partial reset clears pointers, keeps settings
// - width select encoding, four combinations
// - byte order for wide-narrow split
// - half level flag from word count

// ------------------------------------------------------------------
// write-side word buffer
// ------------------------------------------------------------------
module dcbf_word_buf
  import dcbf_pkg::*;
#(
  parameter int W     = 19,
  parameter int DEPTH = BUF_DEPTH_C
)(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         flush_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_q [DEPTH];
  logic [AW:0]   cnt_q, cnt_d;
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic          push, pop;

  // depth must be a power of two so the pointers wrap by themselves
  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rp_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // next pointers and count
  always_comb
  begin
    wp_d  = push ? wp_q + 1'b1 : wp_q;
    rp_d  = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_i)
    begin
      wp_d  = '0;
      rp_d  = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // storage is not reset; the count alone says what is valid
  always_ff @(posedge clk_i)
  begin
    if (push && !flush_i)
      mem_q[wp_q] <= in_data_i;
  end
endmodule

// ------------------------------------------------------------------
// bus-matching buffer core
// ------------------------------------------------------------------
`timescale 1ns/1ps
module dcbf_fifo
  import dcbf_pkg::*;
#(
  parameter int ADDR_W = 10               // memory holds 2**ADDR_W narrow words
)(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        write_clock_i,
  input  wire logic        read_clock_i,
  input  wire logic        write_en_n_i,
  input  wire logic        read_en_n_i,
  input  wire logic        output_drive_en_n_i,
  input  wire logic [17:0] data_in_bus_i,
  input  wire logic        offset_load_n_i,
  input  wire logic        serial_load_en_n_i,
  input  wire logic        fall_through_mode_serial_i,
  input  wire logic        retx_request_n_i,
  input  wire logic        master_reset_n_i,
  input  wire logic        partial_reset_n_i,
  input  wire logic        in_width_sel_i,
  input  wire logic        out_width_sel_i,
  input  wire logic        byte_order_sel_i,
  input  wire logic        flag_sync_select_i,
  input  wire logic        retx_latency_sel_i,
  input  wire logic        default_offset_sel0_i,
  input  wire logic        default_offset_sel1_i,
  input  wire logic        parity_place_sel_i,
  output logic [17:0]      data_out_bus_o,
  output logic             data_out_bus_oe_o,
  output logic             empty_flag_n_o,
  output logic             full_flag_n_o,
  output logic             half_level_n_o,
  output logic             near_empty_n_o,
  output logic             near_full_n_o
);
  localparam int          LW     = ADDR_W + 1;
  localparam logic [LW-1:0] CAP  = LW'(2**ADDR_W);
  localparam logic [LW-1:0] HALF = LW'(2**(ADDR_W-1));

  typedef enum {FS_IDLE, FS_FALL, FS_HELD} dcbf_fall_t;

  dcbf_pins_t            pins_raw, sync1_q, s2_q;
  logic                  wclk_prev_q, rclk_prev_q;
  logic                  wr_edge, rd_edge, rd_tr, master_reset_n, partial_reset_n;
  dcbf_cfg_t             cfg_q, cfg_d;
  logic [ADDR_W-1:0]     ne_ofs_q, ne_ofs_d, nf_ofs_q, nf_ofs_d;
  logic                  ld_sel_q, ld_sel_d, rb_sel_q, rb_sel_d;
  logic [BYTE_W_C-1:0]   mem_q [2**ADDR_W];
  logic [ADDR_W-1:0]     wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [LW-1:0]         level_q, level_d, mcnt_q, mcnt_d, inb, outb, restore;
  logic                  phase_q, phase_d, mem_we, pop, wr_take, full_now, has_word;
  logic [BYTE_W_C-1:0]   wr_byte;
  dcbf_fall_t            fall_q, fall_d;
  logic [1:0]            tcnt_q, tcnt_d;
  logic [17:0]           dout_q, dout_d, rd_word, zero_word;
  logic                  oe_q, ef_q, ef_d, ff_q, ff_d, hf_q, hf_d, ne_q, ne_d, nf_q, nf_d;
  logic                  buf_in_ready, buf_out_valid, buf_out_ready;
  dcbf_buf_word_t        buf_in, buf_out;
  logic [15:0]           par_ofs;

  // ----------------------------------------------------------------
  // pin synchronisers and clock edge detection
  // ----------------------------------------------------------------
  assign pins_raw = {write_clock_i, read_clock_i, write_en_n_i, read_en_n_i, output_drive_en_n_i,
                     offset_load_n_i, serial_load_en_n_i, fall_through_mode_serial_i, retx_request_n_i,
                     master_reset_n_i, partial_reset_n_i, in_width_sel_i, out_width_sel_i,
                     byte_order_sel_i, flag_sync_select_i, retx_latency_sel_i,
                     default_offset_sel0_i, default_offset_sel1_i, parity_place_sel_i, data_in_bus_i};

  // both pin clocks are sampled, so each may stop or run at any rate below half ref
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_q     <= '0;
      s2_q        <= '0;
      wclk_prev_q <= 1'b0;
      rclk_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q     <= pins_raw;
      s2_q        <= sync1_q;
      wclk_prev_q <= s2_q.wclk;
      rclk_prev_q <= s2_q.rclk;
    end
  end

  assign wr_edge = s2_q.wclk & ~wclk_prev_q;
  assign rd_edge = s2_q.rclk & ~rclk_prev_q;
  assign rd_tr   = s2_q.rclk ^ rclk_prev_q;
  assign master_reset_n     = ~s2_q.mrs_n;
  assign partial_reset_n     = ~s2_q.prs_n & ~master_reset_n;

  // ----------------------------------------------------------------
  // mode capture and offset registers (write side)
  // ----------------------------------------------------------------
  assign inb  = cfg_q.in9 ? LW'(1) : LW'(2);
  assign outb = cfg_q.out9 ? LW'(1) : LW'(2);
  // interspersed parity skips bit 8 of a wide word; otherwise the top two bits are dropped
  assign par_ofs = (cfg_q.ip && !cfg_q.in9) ? {s2_q.d[16:9], s2_q.d[7:0]} : s2_q.d[15:0];

  always_comb
  begin
    cfg_d    = cfg_q;
    ne_ofs_d = ne_ofs_q;
    nf_ofs_d = nf_ofs_q;
    ld_sel_d = ld_sel_q;
    if (master_reset_n)
    begin
      cfg_d = '{fall_through_mode: s2_q.si, in9: s2_q.iw, out9: s2_q.ow, little: s2_q.be,
                sync_flags: s2_q.flag_sync_select, norm_rt: s2_q.rm, ip: s2_q.ip};
      ne_ofs_d = ADDR_W'(DEF_OFS_C[{s2_q.default_offset_sel1, s2_q.default_offset_sel0, s2_q.ld_n}]);
      nf_ofs_d = ADDR_W'(DEF_OFS_C[{s2_q.default_offset_sel1, s2_q.default_offset_sel0, s2_q.ld_n}]);
      ld_sel_d = 1'b0;
    end
    else if (partial_reset_n)
      ld_sel_d = 1'b0;                                                         // offsets kept
    else if (wr_edge && !s2_q.ld_n && !s2_q.sen_n)
      {ne_ofs_d, nf_ofs_d} = {ne_ofs_q[ADDR_W-2:0], nf_ofs_q, s2_q.si};
    else if (wr_edge && !s2_q.ld_n && !s2_q.wen_n)
    begin
      if (ld_sel_q)
        nf_ofs_d = ADDR_W'(par_ofs);
      else
        ne_ofs_d = ADDR_W'(par_ofs);
      ld_sel_d = ~ld_sel_q;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg_q    <= '0;
      ne_ofs_q <= '0;
      nf_ofs_q <= '0;
      ld_sel_q <= 1'b0;
    end
    else
    begin
      cfg_q    <= cfg_d;
      ne_ofs_q <= ne_ofs_d;
      nf_ofs_q <= nf_ofs_d;
      ld_sel_q <= ld_sel_d;
    end
  end

  // ----------------------------------------------------------------
  // write path: buffer, byte drain into memory
  // ----------------------------------------------------------------
  // level counts the buffered bytes too, so a taken word always has room
  assign full_now = (level_q + inb) > CAP;
  assign wr_take  = wr_edge & ~s2_q.wen_n & s2_q.ld_n & buf_in_ready & ~full_now & ~master_reset_n & ~partial_reset_n;
  assign buf_in   = '{wide: ~cfg_q.in9, data: s2_q.d};

  dcbf_word_buf #(
    .W     ($bits(dcbf_buf_word_t)),
    .DEPTH (BUF_DEPTH_C)
  ) u_buf (
    .clk_i       (ref_clk_i),
    .rst_i       (rst_i),
    .flush_i     (master_reset_n | partial_reset_n),
    .in_valid_i  (wr_take),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (buf_in),
    .out_valid_o (buf_out_valid),
    .out_ready_i (buf_out_ready),
    .out_data_o  (buf_out)
  );

  // a wide word drains as two bytes, first byte is the one read out first
  always_comb
  begin
    mem_we        = buf_out_valid & ~master_reset_n & ~partial_reset_n;
    buf_out_ready = mem_we & (~buf_out.wide | phase_q);
    phase_d       = (mem_we & buf_out.wide) ? ~phase_q : phase_q;
    if (!buf_out.wide)
      wr_byte = buf_out.data[8:0];
    else if (phase_q ^ cfg_q.little)
      wr_byte = buf_out.data[8:0];
    else
      wr_byte = buf_out.data[17:9];
    wr_ptr_d = mem_we ? wr_ptr_q + 1'b1 : wr_ptr_q;
    if (master_reset_n || partial_reset_n)
    begin
      phase_d  = 1'b0;
      wr_ptr_d = '0;
    end
  end

  // memory array is not reset; its count guards every read
  always_ff @(posedge ref_clk_i)
  begin
    if (mem_we)
      mem_q[wr_ptr_q] <= wr_byte;
  end

  // ----------------------------------------------------------------
  // read path and output register
  // ----------------------------------------------------------------
  assign has_word  = mcnt_q >= outb;
  assign rd_word   = cfg_q.out9 ? {9'h000, mem_q[rd_ptr_q]} : {mem_q[rd_ptr_q], mem_q[rd_ptr_q + 1'b1]};
  assign zero_word = cfg_q.out9 ? {9'h000, mem_q[0]} : {mem_q[0], mem_q[1]};

  always_comb
  begin
    rd_ptr_d = rd_ptr_q;
    fall_d   = fall_q;
    tcnt_d   = tcnt_q;
    dout_d   = dout_q;
    rb_sel_d = rb_sel_q;
    pop      = 1'b0;
    restore  = '0;
    if (master_reset_n)
    begin
      rd_ptr_d = '0;
      fall_d   = FS_IDLE;
      tcnt_d   = '0;
      dout_d   = '0;
      rb_sel_d = 1'b0;
    end
    else if (partial_reset_n)
    begin
      rd_ptr_d = '0;
      fall_d   = FS_IDLE;
      tcnt_d   = '0;
      rb_sel_d = 1'b0;
    end
    else if (rd_edge && !s2_q.rt_n)
    begin
      // rereading only works while the writer has not wrapped the array
      restore  = LW'(rd_ptr_q);
      rd_ptr_d = '0;
      fall_d   = FS_IDLE;
      tcnt_d   = '0;
      if (!cfg_q.norm_rt && (mcnt_q + LW'(rd_ptr_q)) >= outb)
      begin
        dout_d   = zero_word;
        rd_ptr_d = ADDR_W'(outb);
        pop      = 1'b1;
        fall_d   = FS_HELD;
      end
    end
    else if (rd_edge && !s2_q.ren_n && !s2_q.ld_n)
    begin
      dout_d   = rb_sel_q ? 18'(nf_ofs_q) : 18'(ne_ofs_q);
      rb_sel_d = ~rb_sel_q;
    end
    else if (!cfg_q.fall_through_mode)
    begin
      if (rd_edge && !s2_q.ren_n && has_word)
      begin
        dout_d = rd_word;
        pop    = 1'b1;
      end
    end
    else
    begin
      case (fall_q)
        FS_IDLE:
          if (has_word)
            fall_d = FS_FALL;
        FS_FALL:
          if (!has_word)
          begin
            fall_d = FS_IDLE;
            tcnt_d = '0;
          end
          else if (rd_tr && tcnt_q == 2'(FALL_TRANS_C - 1))
          begin
            dout_d = rd_word;
            pop    = 1'b1;
            fall_d = FS_HELD;
            tcnt_d = '0;
          end
          else if (rd_tr)
            tcnt_d = tcnt_q + 2'h1;
        FS_HELD:
          if (rd_edge && !s2_q.ren_n)
          begin
            if (has_word)
            begin
              dout_d = rd_word;
              pop    = 1'b1;
            end
            else
              fall_d = FS_IDLE;
          end
        default:
          fall_d = FS_IDLE;
      endcase
    end
    if (pop && !(rd_edge && !s2_q.rt_n))
      rd_ptr_d = rd_ptr_q + ADDR_W'(outb);
  end

  // ----------------------------------------------------------------
  // fill counts and flags
  // ----------------------------------------------------------------
  always_comb
  begin
    level_d = level_q + (wr_take ? inb : LW'(0)) + restore - (pop ? outb : LW'(0));
    mcnt_d  = mcnt_q + LW'(mem_we) + restore - (pop ? outb : LW'(0));
    if (master_reset_n || partial_reset_n)
    begin
      level_d = '0;
      mcnt_d  = '0;
    end
    ef_d = ef_q;
    ff_d = ff_q;
    hf_d = hf_q;
    ne_d = ne_q;
    nf_d = nf_q;
    if (master_reset_n)
    begin
      ef_d = s2_q.si;
      ff_d = ~s2_q.si;
      hf_d = HALF_RST_C;
      ne_d = NEAR_E_RST_C;
      nf_d = NEAR_F_RST_C;
    end
    else
    begin
      ef_d = cfg_q.fall_through_mode ? (fall_d != FS_HELD) : (mcnt_d >= outb);
      ff_d = cfg_q.fall_through_mode ? ((level_d + inb) > CAP) : ((level_d + inb) <= CAP);
      hf_d = ~(level_d > HALF);
      // asynchronous mode follows either clock: reads pull it low, writes release it
      if (partial_reset_n || rd_edge || (!cfg_q.sync_flags && wr_edge))
        ne_d = level_d > LW'(ne_ofs_q);
      if (partial_reset_n || wr_edge || (!cfg_q.sync_flags && rd_edge))
        nf_d = level_d < (CAP - LW'(nf_ofs_q));
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      phase_q  <= 1'b0;
      level_q  <= '0;
      mcnt_q   <= '0;
      fall_q   <= FS_IDLE;
      tcnt_q   <= '0;
      rb_sel_q <= 1'b0;
      dout_q   <= '0;
      oe_q     <= 1'b0;
      ef_q     <= 1'b0;
      ff_q     <= 1'b1;
      hf_q     <= HALF_RST_C;
      ne_q     <= NEAR_E_RST_C;
      nf_q     <= NEAR_F_RST_C;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      phase_q  <= phase_d;
      level_q  <= level_d;
      mcnt_q   <= mcnt_d;
      fall_q   <= fall_d;
      tcnt_q   <= tcnt_d;
      rb_sel_q <= rb_sel_d;
      dout_q   <= dout_d;
      oe_q     <= ~s2_q.oe_n;
      ef_q     <= ef_d;
      ff_q     <= ff_d;
      hf_q     <= hf_d;
      ne_q     <= ne_d;
      nf_q     <= nf_d;
    end
  end

  assign data_out_bus_o    = dout_q;
  assign data_out_bus_oe_o = oe_q;
  assign empty_flag_n_o    = ef_q;
  assign full_flag_n_o     = ff_q;
  assign half_level_n_o    = hf_q;
  assign near_empty_n_o    = ne_q;
  assign near_full_n_o     = nf_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_mrs_flags:    assert property (master_reset_n |=> !near_empty_n_o && near_full_n_o && half_level_n_o
                                    && data_out_bus_o == '0 && rd_ptr_q == '0 && wr_ptr_q == '0)
    else $error("master reset did not clear flags and pointers");
  a_write_level:  assert property (wr_take && !pop && restore == '0 |=> level_q == $past(level_q) + $past(inb))
    else $error("accepted write did not raise the level");
  a_std_read:     assert property (!cfg_q.fall_through_mode && rd_edge && !s2_q.ren_n && s2_q.ld_n && s2_q.rt_n && has_word
                                   && !master_reset_n && !partial_reset_n |=> data_out_bus_o == $past(rd_word))
    else $error("standard read did not present the next word");
  a_oe_follow:    assert property (s2_q.oe_n |=> !data_out_bus_oe_o ##1 1'b1)
    else $error("outputs driven while output enable inactive");
  a_std_hold:     assert property (!cfg_q.fall_through_mode && !rd_edge && !master_reset_n |=> $stable(data_out_bus_o))
    else $error("standard mode output changed without a read edge");
  a_fall_third:   assert property (cfg_q.fall_through_mode && fall_q == FS_FALL && tcnt_q == 2'h2 && rd_tr && has_word
                                   && !master_reset_n && !partial_reset_n && !(rd_edge && !s2_q.rt_n) && !(rd_edge && !s2_q.ren_n && !s2_q.ld_n)
                                   |=> fall_q == FS_HELD ##1 !empty_flag_n_o)
    else $error("first word did not fall through on the third transition");
  a_level_bound:  assert property (level_q <= CAP && mcnt_q <= level_q)
    else $error("fill level ran past capacity");
  a_retx_ptr:     assert property (rd_edge && !s2_q.rt_n && !master_reset_n && !partial_reset_n && cfg_q.norm_rt |=> rd_ptr_q == '0)
    else $error("retransmit did not rewind the read pointer");
  a_ne_sync:      assert property (cfg_q.sync_flags && !rd_edge && !master_reset_n && !partial_reset_n |=> $stable(near_empty_n_o))
    else $error("synchronous near-empty moved without a read edge");
  a_half_level:   assert property (half_level_n_o == !(level_q > HALF))
    else $error("half level flag missed a count above half");

  c_fall_through: cover property (cfg_q.fall_through_mode && fall_q == FS_FALL ##[1:20] fall_q == FS_HELD);
  c_retx_zero:    cover property (rd_edge && !s2_q.rt_n && !cfg_q.norm_rt && !master_reset_n && !partial_reset_n);
  c_serial_load:  cover property (wr_edge && !s2_q.ld_n && !s2_q.sen_n && !master_reset_n);
  c_buffer_full:  cover property (!full_now ##1 full_now);
endmodule

// >>> verif/dcbf_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// writer and reader host model
// ----------------------------------------------------------------
module dcbf_host (
  input  wire logic   clk_i,
  output logic        wclk_o,
  output logic        rclk_o,
  output logic        wen_n_o,
  output logic        ren_n_o,
  output logic [17:0] d_o
);
  // clocks stand still between accesses, unlike a free-running source
  initial
  begin
    wclk_o  = 1'b0;
    rclk_o  = 1'b0;
    wen_n_o = 1'b1;
    ren_n_o = 1'b1;
    d_o     = 18'h3ffff;
  end

  // one write clock pulse; the bus is inverted once the edge has passed
  task automatic wr(input logic [17:0] v);
    @(negedge clk_i);
    wen_n_o = 1'b0;
    d_o     = v;
    repeat (3) @(negedge clk_i);
    wclk_o = 1'b1;
    repeat (3) @(negedge clk_i);
    wclk_o  = 1'b0;
    wen_n_o = 1'b1;
    d_o     = ~v;
  endtask

  // one read clock transition, enable held across it
  task automatic rtog(input logic en);
    @(negedge clk_i);
    ren_n_o = ~en;
    repeat (3) @(negedge clk_i);
    rclk_o = ~rclk_o;
    repeat (3) @(negedge clk_i);
    ren_n_o = 1'b1;
  endtask
endmodule

// >>> verif/dual_clock_bus_matching_fifo_tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// self-checking bench
// ----------------------------------------------------------------
module dual_clock_bus_matching_fifo_tb;
  import dcbf_pkg::*;
  logic ref_clk_i, rst_i, oe_n, ld_n, sen_n, si, rt_n, mrs_n, prs_n;
  logic [7:0] cfg;
  logic wclk, rclk, wen_n, ren_n, oe, ef, ff, hf, near_empty_n, near_full_n;
  logic [17:0] d, q;
  int mismatches = 0;
  int comparisons = 0;

  dcbf_host i_dcbf_host (.clk_i(ref_clk_i), .wclk_o(wclk), .rclk_o(rclk), .wen_n_o(wen_n), .ren_n_o(ren_n),
    .d_o(d));

  // small memory keeps fill and drain short: 16 narrow words
  dcbf_fifo #(.ADDR_W(4)) i_dcbf_fifo (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .write_clock_i(wclk),
    .read_clock_i(rclk), .write_en_n_i(wen_n), .read_en_n_i(ren_n), .output_drive_en_n_i(oe_n),
    .data_in_bus_i(d), .offset_load_n_i(ld_n), .serial_load_en_n_i(sen_n), .fall_through_mode_serial_i(si),
    .retx_request_n_i(rt_n), .master_reset_n_i(mrs_n), .partial_reset_n_i(prs_n),
    .in_width_sel_i(cfg[0]), .out_width_sel_i(cfg[1]), .byte_order_sel_i(cfg[2]),
    .flag_sync_select_i(cfg[3]), .retx_latency_sel_i(cfg[4]), .default_offset_sel0_i(cfg[5]),
    .default_offset_sel1_i(cfg[6]), .parity_place_sel_i(cfg[7]), .data_out_bus_o(q),
    .data_out_bus_oe_o(oe), .empty_flag_n_o(ef), .full_flag_n_o(ff), .half_level_n_o(hf),
    .near_empty_n_o(near_empty_n), .near_full_n_o(near_full_n));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // master reset with the timing mode on the shared pin
  task automatic mreset(input logic ft);
    si    = ft;
    mrs_n = 1'b0;
    repeat (8) @(negedge ref_clk_i);
    chk({near_empty_n, near_full_n, hf, ef, ff}, {3'b011, ft, ~ft});
    chk(q, 18'h0);
    mrs_n = 1'b1;
    repeat (6) @(negedge ref_clk_i);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_std();
    mreset(1'b0);
    i_dcbf_host.wr(18'h2a5b3);
    repeat (4) @(negedge ref_clk_i);
    chk({ef, q}, {1'b1, 18'h0});
    i_dcbf_host.rtog(1'b1);
    i_dcbf_host.rtog(1'b0);
    chk({ef, q}, {1'b0, 18'h2a5b3});
    $display("test_std done");
  endtask

  // the ninth word is refused, so a ninth read keeps the eighth word
  task automatic test_full();
    mreset(1'b0);
    for (int i = 0; i < 9; i++)
      i_dcbf_host.wr(18'h100 + 18'(i));
    repeat (4) @(negedge ref_clk_i);
    chk({ff, hf}, 2'b00);
    for (int i = 0; i < 9; i++)
    begin
      i_dcbf_host.rtog(1'b1);
      i_dcbf_host.rtog(1'b0);
      chk(q, 18'h100 + 18'(i < 8 ? i : 7));
    end
    chk({ef, ff, hf}, 3'b011);
    $display("test_full done");
  endtask

  task automatic test_ft();
    mreset(1'b1);
    i_dcbf_host.wr(18'h155aa);
    i_dcbf_host.rtog(1'b0);
    i_dcbf_host.rtog(1'b0);
    chk({ef, q}, {1'b1, 18'h0});
    i_dcbf_host.rtog(1'b0);
    chk({ef, q}, {1'b0, 18'h155aa});
    i_dcbf_host.rtog(1'b0);
    $display("test_ft done");
  endtask

  task automatic test_oe();
    oe_n = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    chk(oe, 1'b0);
    oe_n = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    chk(oe, 1'b1);
    $display("test_oe done");
  endtask

  // wide in, narrow out, low byte first, synchronous flags; normal retransmit, then partial reset
  task automatic test_narrow();
    cfg = 8'h1e;
    mreset(1'b0);
    i_dcbf_host.wr(18'h2a5b3);
    i_dcbf_host.rtog(1'b1);
    i_dcbf_host.rtog(1'b0);
    chk(q, 18'h001b3);
    i_dcbf_host.rtog(1'b1);
    i_dcbf_host.rtog(1'b0);
    chk({ef, q}, {1'b0, 18'h00152});
    rt_n = 1'b0;
    i_dcbf_host.rtog(1'b0);
    rt_n = 1'b1;
    i_dcbf_host.rtog(1'b0);
    chk({ef, q}, {1'b1, 18'h00152});
    i_dcbf_host.rtog(1'b1);
    chk(q, 18'h001b3);
    prs_n = 1'b0;
    repeat (6) @(negedge ref_clk_i);
    prs_n = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    i_dcbf_host.rtog(1'b0);
    i_dcbf_host.rtog(1'b1);
    chk({ef, hf, near_empty_n, q}, {3'b010, 18'h001b3});
    i_dcbf_host.rtog(1'b0);
    $display("test_narrow done");
  endtask

  // default offsets from the select pins, then parallel load and readback of both offsets
  task automatic test_ofs();
    cfg = 8'h60;
    mreset(1'b0);
    ld_n = 1'b0;
    i_dcbf_host.rtog(1'b1);
    i_dcbf_host.rtog(1'b0);
    chk(q, 18'(DEF_OFS_C[7][3:0]));
    i_dcbf_host.wr(18'h00005);
    i_dcbf_host.wr(18'h00009);
    i_dcbf_host.rtog(1'b1);
    i_dcbf_host.rtog(1'b0);
    chk(q, 18'h00009);
    i_dcbf_host.rtog(1'b1);
    i_dcbf_host.rtog(1'b0);
    chk(q, 18'h00005);
    cfg = 8'h00;
    mreset(1'b0);
    i_dcbf_host.rtog(1'b1);
    i_dcbf_host.rtog(1'b0);
    chk(q, 18'(DEF_OFS_C[0][3:0]));
    ld_n = 1'b1;
    $display("test_ofs done");
  endtask

  // ----------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  initial
  begin
    {rst_i, mrs_n, prs_n, ld_n, sen_n, rt_n, si} = 7'h7e;
    oe_n = 1'b0;
    cfg  = 8'h0;
    repeat (12) @(negedge ref_clk_i);
    rst_i = 1'b0;
    test_std();
    test_full();
    test_ft();
    test_oe();
    test_narrow();
    test_ofs();
    summarize();
  end

  // whole run needs well under 2000 reference cycles
  initial
  begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule
